// ### design/iqsme_pkg.sv
// Constants, types and register map of the I/Q symbol mapper engine
package iqsme_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int BUF_BITS = 4096;
  localparam int BUF_AW = 12;
  localparam int POS_W = 13;
  localparam int WORD_AW = 7;
  localparam int W_MAX = 4;
  localparam int SAMP_AW = 6;
  localparam int DAC_W = 12;

  // ----------------------------------------------------------------
  // DAC code range
  // ----------------------------------------------------------------
  localparam logic signed [15:0] DAC_MAX = 16'sh0555;
  localparam logic signed [15:0] DAC_BIAS = 16'sh02ab;

  // ----------------------------------------------------------------
  // Imbalance scale factors, fixed point with FRAC_SH fraction bits
  // ----------------------------------------------------------------
  localparam logic signed [7:0] AMP_RECIP = 8'sh29;
  localparam logic signed [7:0] PH_RECIP = 8'sh47;
  localparam int FRAC_SH = 12;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_PATLEN = 8'h08;
  localparam logic [7:0] OFS_SHIFT = 8'h0c;
  localparam logic [7:0] OFS_BITLEN = 8'h10;
  localparam logic [7:0] OFS_BITADDR = 8'h14;
  localparam logic [7:0] OFS_BITDATA = 8'h18;
  localparam logic [7:0] OFS_PATADDR = 8'h1c;
  localparam logic [7:0] OFS_PATDATA = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0;
  localparam int CTRL_SP_LSB = 1;
  localparam int CTRL_CV_LSB = 4;
  localparam int CTRL_WID_LSB = 6;
  localparam int CTRL_ORD_LSB = 10;
  localparam int SHIFT_PH_LSB = 8;
  localparam int PAT_Q_LSB = 16;
  localparam int ST_LENERR = 1;
  localparam int ST_POS_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] CTRL_RST = 14'h0453;
  localparam logic [15:0] STEP_RST = 16'h001e;
  localparam logic [6:0] PATLEN_RST = 7'h24;
  localparam logic [15:0] SHIFT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SP_BYPASS = 3'h1,
    SP_GROUP = 3'h2,
    SP_INTL = 3'h3,
    SP_MSK = 3'h4
  } iqsme_sp_t;

  typedef enum logic [1:0] {
    CV_BYPASS = 2'h1,
    CV_GRAY = 2'h2,
    CV_GMSK = 2'h3
  } iqsme_cv_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } iqsme_state_t;

endpackage

// ### design/iqsme_conv_if.sv
// Carrier between the engine and its code converter
`timescale 1ns/1ps
interface iqsme_conv_if;
  logic [iqsme_pkg::W_MAX-1:0] word_in;
  logic stb;
  iqsme_pkg::iqsme_cv_t mode;
  logic [iqsme_pkg::W_MAX-1:0] word_out;

  modport eng (output word_in, output stb, output mode, input word_out);
  modport conv (input word_in, input stb, input mode, output word_out);
endinterface

// ### design/iqsme_conv.sv
// Code converter: bypass, Gray code, GMSK filter
`timescale 1ns/1ps
module iqsme_conv (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Word stream
  iqsme_conv_if.conv cv
);

  localparam int W = iqsme_pkg::W_MAX;

  logic [1:0] hist_q;
  logic [1:0] hist_d;
  wire logic [W-1:0] gray_w;
  wire logic [W-1:0] gmsk_w;

  assign gray_w = (cv.word_in >> 1) ^ cv.word_in;
  // Filtered symbol is the current bit with its two predecessors, so
  // each stored pattern can hold a smoothed trajectory
  assign gmsk_w = W'({hist_q, cv.word_in[0]});

  assign cv.word_out = (cv.mode == iqsme_pkg::CV_GRAY) ? gray_w :
                       (cv.mode == iqsme_pkg::CV_GMSK) ? gmsk_w :
                       cv.word_in;

  assign hist_d = cv.stb ? {hist_q[0], cv.word_in[0]} : hist_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hist_q <= 2'h0;
    end else begin
      hist_q <= hist_d;
    end
  end

endmodule

// ### design/iqsme_engine.sv
// I/Q symbol mapper engine: bit buffer, S/P stage, patterns, DAC feed
`timescale 1ns/1ps
module iqsme_engine #(
  parameter int W_MAX = iqsme_pkg::W_MAX,
  parameter int SAMP_AW = iqsme_pkg::SAMP_AW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // DAC
  output logic [iqsme_pkg::DAC_W-1:0] dac_i,
  output logic [iqsme_pkg::DAC_W-1:0] dac_q,
  output logic dac_load
);

  localparam int PW = iqsme_pkg::POS_W;
  localparam int PAT_AW = W_MAX + SAMP_AW;
  localparam int DW = iqsme_pkg::DAC_W;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] bit_mem [0:(iqsme_pkg::BUF_BITS/32)-1];
  logic [2*DW-1:0] pat_mem [0:(1<<PAT_AW)-1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [13:0] ctrl_q;
  logic [15:0] step_q;
  logic [6:0] patlen_q;
  logic [15:0] shift_q;
  logic [PW-1:0] bitlen_q;
  logic [iqsme_pkg::WORD_AW-1:0] bit_addr_q;
  logic [PAT_AW-1:0] pat_addr_q;
  logic [31:0] rdata_q;

  iqsme_pkg::iqsme_state_t state_q;
  iqsme_pkg::iqsme_state_t state_d;
  logic [PW-1:0] pos_q;
  logic [1:0] intl_j_q;
  logic prev_bit_q;
  logic [W_MAX-1:0] sym_q;
  logic [SAMP_AW-1:0] samp_q;
  logic [15:0] step_cnt_q;
  logic [2*DW-1:0] pat_rd_q;
  logic rd_vld_q;
  logic [DW-1:0] dac_i_q;
  logic [DW-1:0] dac_q_q;
  logic dac_load_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire logic enable = ctrl_q[iqsme_pkg::CTRL_EN];
  wire logic [2:0] sp_f = ctrl_q[iqsme_pkg::CTRL_SP_LSB +: 3];
  wire logic [1:0] cv_f = ctrl_q[iqsme_pkg::CTRL_CV_LSB +: 2];
  wire logic [3:0] wid_f = ctrl_q[iqsme_pkg::CTRL_WID_LSB +: 4];
  wire logic [3:0] ord_f = ctrl_q[iqsme_pkg::CTRL_ORD_LSB +: 4];
  wire logic signed [7:0] amp_s = shift_q[7:0];
  wire logic signed [7:0] ph_s = shift_q[iqsme_pkg::SHIFT_PH_LSB +: 8];

  wire logic wr_ctrl = reg_wr && (reg_addr == iqsme_pkg::OFS_CTRL);
  wire logic wr_step = reg_wr && (reg_addr == iqsme_pkg::OFS_STEP);
  wire logic wr_plen = reg_wr && (reg_addr == iqsme_pkg::OFS_PATLEN);
  wire logic wr_shift = reg_wr && (reg_addr == iqsme_pkg::OFS_SHIFT);
  wire logic wr_blen = reg_wr && (reg_addr == iqsme_pkg::OFS_BITLEN);
  wire logic wr_baddr = reg_wr && (reg_addr == iqsme_pkg::OFS_BITADDR);
  wire logic wr_bdata = reg_wr && (reg_addr == iqsme_pkg::OFS_BITDATA);
  wire logic wr_paddr = reg_wr && (reg_addr == iqsme_pkg::OFS_PATADDR);
  wire logic wr_pdata = reg_wr && (reg_addr == iqsme_pkg::OFS_PATDATA);

  // Width clamped to 1..W_MAX so a bad setting cannot overrun the word
  wire logic [2:0] w_eff = (wid_f == 4'h0) ? 3'h1 :
                           (wid_f > 4'(W_MAX)) ? 3'(W_MAX) : wid_f[2:0];
  wire logic [3:0] ord_eff = (ord_f == 4'h0) ? 4'h1 : ord_f;
  // Flags a stream that exceeds what the bit buffer can expand
  wire logic len_err = (17'(bitlen_q) * 17'(ord_eff)) >
                       17'(iqsme_pkg::BUF_BITS);

  // ----------------------------------------------------------------
  // Serial-to-parallel stage
  // ----------------------------------------------------------------
  function automatic logic get_bit(input logic [PW-1:0] idx);
    logic [31:0] wd;
    wd = bit_mem[idx[iqsme_pkg::BUF_AW-1:5]];
    return wd[idx[4:0]];
  endfunction

  // Bits gathered first-in at the word's MSB
  function automatic logic [W_MAX-1:0] gather(
    input logic [PW-1:0] base,
    input logic [PW-1:0] stride,
    input logic [2:0] w
  );
    logic [W_MAX-1:0] r;
    logic [PW-1:0] idx;
    r = '0;
    idx = base;
    for (int k = 0; k < W_MAX; k++) begin
      if (k < int'(w)) begin
        r = {r[W_MAX-2:0], get_bit(idx)};
        idx = idx + stride;
      end
    end
    return r;
  endfunction

  wire logic [PW-1:0] w_pos = PW'(w_eff);
  wire logic [PW-1:0] blk_len = PW'(w_eff * w_eff);
  wire logic [PW-1:0] intl_base = pos_q + PW'(intl_j_q);
  wire logic cur_bit = get_bit(pos_q);
  wire logic [W_MAX-1:0] grp_word = gather(pos_q, PW'(1), w_eff);
  wire logic [W_MAX-1:0] int_word = gather(intl_base, w_pos, w_eff);
  // Pairs each bit with its predecessor so patterns follow transitions
  wire logic [W_MAX-1:0] msk_word = W_MAX'({prev_bit_q, cur_bit});

  wire logic [W_MAX-1:0] sp_word =
    (sp_f == iqsme_pkg::SP_GROUP) ? grp_word :
    (sp_f == iqsme_pkg::SP_INTL) ? int_word :
    (sp_f == iqsme_pkg::SP_MSK) ? msk_word :
    W_MAX'(cur_bit);

  wire logic intl_last = ({1'b0, intl_j_q} == (w_eff - 3'h1));
  wire logic [PW-1:0] pos_step =
    (sp_f == iqsme_pkg::SP_GROUP) ? (pos_q + w_pos) :
    (sp_f == iqsme_pkg::SP_INTL) ? (intl_last ? pos_q + blk_len : pos_q) :
    (pos_q + PW'(1));
  wire logic [PW-1:0] pos_lim = (sp_f == iqsme_pkg::SP_INTL) ?
                                (pos_q + blk_len) : pos_step;
  wire logic pos_wrap = (pos_lim >= bitlen_q) &&
                        ((sp_f != iqsme_pkg::SP_INTL) || intl_last);
  wire logic [PW-1:0] pos_nxt = pos_wrap ? '0 : pos_step;
  wire logic [1:0] j_nxt = (pos_wrap || intl_last) ? 2'h0 : intl_j_q + 2'h1;

  // ----------------------------------------------------------------
  // Code converter
  // ----------------------------------------------------------------
  iqsme_conv_if cvi ();

  iqsme_conv u_conv (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .cv(cvi.conv)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire logic [15:0] step_eff = (step_q == 16'h0) ? 16'h1 : step_q;
  wire logic run = (state_q == iqsme_pkg::ST_RUN);
  wire logic tick = run && (step_cnt_q == step_eff - 16'h1);
  wire logic [6:0] plen_eff = (patlen_q == 7'h0) ? 7'h1 :
                              (patlen_q > 7'(1 << SAMP_AW)) ?
                              7'(1 << SAMP_AW) : patlen_q;
  wire logic samp_last = (7'(samp_q) == plen_eff - 7'h1);
  wire logic load = (state_q == iqsme_pkg::ST_LOAD);
  wire logic adv = load || (tick && samp_last);

  assign cvi.word_in = sp_word;
  assign cvi.stb = adv;
  assign cvi.mode = iqsme_pkg::iqsme_cv_t'(cv_f);

  always_comb begin
    state_d = state_q;
    case (state_q)
      iqsme_pkg::ST_IDLE: begin
        if (enable && (bitlen_q != '0)) begin
          state_d = iqsme_pkg::ST_LOAD;
        end
      end
      iqsme_pkg::ST_LOAD: begin
        state_d = iqsme_pkg::ST_RUN;
      end
      iqsme_pkg::ST_RUN: begin
        state_d = iqsme_pkg::ST_RUN;
      end
      default: begin
        state_d = iqsme_pkg::ST_IDLE;
      end
    endcase
    if (!enable) begin
      state_d = iqsme_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= iqsme_pkg::ST_IDLE;
      pos_q <= '0;
      intl_j_q <= 2'h0;
      prev_bit_q <= 1'b0;
      sym_q <= '0;
      samp_q <= '0;
      step_cnt_q <= 16'h0;
    end else begin
      state_q <= state_d;
      step_cnt_q <= (!run || tick) ? 16'h0 : step_cnt_q + 16'h1;
      if (state_q == iqsme_pkg::ST_IDLE) begin
        pos_q <= '0;
        intl_j_q <= 2'h0;
        samp_q <= '0;
      end else if (adv) begin
        pos_q <= pos_nxt;
        intl_j_q <= j_nxt;
        prev_bit_q <= cur_bit;
        sym_q <= cvi.word_out;
        samp_q <= '0;
      end else if (tick) begin
        samp_q <= samp_q + SAMP_AW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Pattern fetch and imbalance correction
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    pat_rd_q <= pat_mem[{sym_q, samp_q}];
    if (wr_pdata) begin
      pat_mem[pat_addr_q] <= {reg_wdata[iqsme_pkg::PAT_Q_LSB +: DW],
                              reg_wdata[DW-1:0]};
    end
    if (wr_bdata) begin
      bit_mem[bit_addr_q] <= reg_wdata;
    end
  end

  wire logic signed [15:0] q_dev = $signed({4'h0, pat_rd_q[2*DW-1:DW]}) -
                                   iqsme_pkg::DAC_BIAS;
  wire logic signed [15:0] i_dev = $signed({4'h0, pat_rd_q[DW-1:0]}) -
                                   iqsme_pkg::DAC_BIAS;
  // Small-angle rotation: large phase settings lose accuracy
  wire logic signed [31:0] q_amp = (32'(q_dev) * 32'(amp_s) *
                                    32'(iqsme_pkg::AMP_RECIP))
                                   >>> iqsme_pkg::FRAC_SH;
  wire logic signed [31:0] i_ph = (32'(q_dev) * 32'(ph_s) *
                                   32'(iqsme_pkg::PH_RECIP))
                                  >>> iqsme_pkg::FRAC_SH;
  // Zero settings give zero correction terms, samples up to DAC_MAX pass exactly
  wire logic signed [31:0] q_sum = 32'(q_dev) + q_amp +
                                   32'(iqsme_pkg::DAC_BIAS);
  wire logic signed [31:0] i_sum = 32'(i_dev) + i_ph +
                                   32'(iqsme_pkg::DAC_BIAS);

  function automatic logic [DW-1:0] clamp(input logic signed [31:0] v);
    logic [DW-1:0] r;
    r = (v < 0) ? '0 :
        (v > 32'(iqsme_pkg::DAC_MAX)) ? DW'(iqsme_pkg::DAC_MAX) :
        v[DW-1:0];
    return r;
  endfunction

  wire logic [DW-1:0] q_out = clamp(q_sum);
  wire logic [DW-1:0] i_out = clamp(i_sum);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_vld_q <= 1'b0;
      dac_i_q <= DW'(iqsme_pkg::DAC_BIAS);
      dac_q_q <= DW'(iqsme_pkg::DAC_BIAS);
      dac_load_q <= 1'b0;
    end else begin
      rd_vld_q <= tick;
      dac_load_q <= rd_vld_q;
      if (rd_vld_q) begin
        dac_i_q <= i_out;
        dac_q_q <= q_out;
      end
    end
  end

  assign dac_i = dac_i_q;
  assign dac_q = dac_q_q;
  assign dac_load = dac_load_q;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire logic [31:0] status_w = {17'h0, pos_q, len_err, run};
  wire logic [31:0] rd_mux =
    (reg_addr == iqsme_pkg::OFS_CTRL) ? 32'(ctrl_q) :
    (reg_addr == iqsme_pkg::OFS_STEP) ? 32'(step_q) :
    (reg_addr == iqsme_pkg::OFS_PATLEN) ? 32'(patlen_q) :
    (reg_addr == iqsme_pkg::OFS_SHIFT) ? 32'(shift_q) :
    (reg_addr == iqsme_pkg::OFS_BITLEN) ? 32'(bitlen_q) :
    (reg_addr == iqsme_pkg::OFS_BITADDR) ? 32'(bit_addr_q) :
    (reg_addr == iqsme_pkg::OFS_PATADDR) ? 32'(pat_addr_q) :
    (reg_addr == iqsme_pkg::OFS_STATUS) ? status_w : 32'h0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= iqsme_pkg::CTRL_RST;
      step_q <= iqsme_pkg::STEP_RST;
      patlen_q <= iqsme_pkg::PATLEN_RST;
      shift_q <= iqsme_pkg::SHIFT_RST;
      bitlen_q <= '0;
      bit_addr_q <= '0;
      pat_addr_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
      if (wr_ctrl) ctrl_q <= reg_wdata[13:0];
      if (wr_step) step_q <= reg_wdata[15:0];
      if (wr_plen) patlen_q <= reg_wdata[6:0];
      if (wr_shift) shift_q <= reg_wdata[15:0];
      if (wr_blen) bitlen_q <= reg_wdata[PW-1:0];
      if (wr_baddr) begin
        bit_addr_q <= reg_wdata[iqsme_pkg::WORD_AW-1:0];
      end else if (wr_bdata) begin
        bit_addr_q <= bit_addr_q + 7'h1;
      end
      if (wr_paddr) begin
        pat_addr_q <= reg_wdata[PAT_AW-1:0];
      end else if (wr_pdata) begin
        pat_addr_q <= pat_addr_q + PAT_AW'(1);
      end
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// ### bench/iqsme_engine_assertions.sv
// Port-level checks bound onto the I/Q symbol mapper engine
`timescale 1ns/1ps
module iqsme_engine_assertions #(
  parameter int W_MAX = iqsme_pkg::W_MAX,
  parameter int SAMP_AW = iqsme_pkg::SAMP_AW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // DAC
  input wire logic [iqsme_pkg::DAC_W-1:0] dac_i,
  input wire logic [iqsme_pkg::DAC_W-1:0] dac_q,
  input wire logic dac_load
);
  logic [15:0] step_q;
  logic [15:0] gap_q;
  logic gap_ok_q;
  logic [2:0] off_q;
  wire wr_step = reg_wr && (reg_addr == iqsme_pkg::OFS_STEP);
  wire wr_ctrl = reg_wr && (reg_addr == iqsme_pkg::OFS_CTRL);
  wire [15:0] step_eff = (step_q == 16'h0000) ? 16'h0001 : step_q;

  // ----------------------------------------------------------------
  // Shadow of the step count and load spacing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) step_q <= iqsme_pkg::STEP_RST;
    else if (wr_step) step_q <= reg_wdata[15:0];
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) gap_q <= 16'h0000;
    else if (dac_load) gap_q <= 16'h0001;
    else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
  end
  // Any register write may retime the stream, so spacing restarts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) gap_ok_q <= 1'b0;
    else if (reg_wr) gap_ok_q <= 1'b0;
    else if (dac_load) gap_ok_q <= 1'b1;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) off_q <= 3'h0;
    else if (wr_ctrl) off_q <= reg_wdata[0] ? 3'h0 : 3'h1;
    else if (off_q != 3'h0 && off_q != 3'h7) off_q <= off_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_RST_BIAS: assert property ($rose(arst_n) |->
    dac_i == 12'h2ab && dac_q == 12'h2ab && !dac_load)
    else $error("dac outputs not at bias after reset");
  AST_CODE_RANGE: assert property (
    dac_i <= 12'h555 && dac_q <= 12'h555)
    else $error("dac code above top of range");
  AST_LOAD_GAP: assert property (
    dac_load && gap_ok_q |-> gap_q == step_eff)
    else $error("sample spacing differs from step count");
  AST_LOAD_PULSE: assert property (
    dac_load && step_eff > 16'h0001 |=> !dac_load)
    else $error("dac load longer than one cycle");
  AST_DAC_HOLD: assert property (
    !dac_load |-> $stable(dac_i) && $stable(dac_q))
    else $error("dac code moved without a load");
  AST_IDLE_QUIET: assert property (
    off_q >= 3'h5 |-> !dac_load)
    else $error("dac load while disabled");
  AST_START_BOUND: assert property (
    wr_ctrl && reg_wdata[0] && off_q != 3'h0 |-> ##[3:300] dac_load)
    else $error("no sample after enable");
  AST_STEP_READ: assert property (
    reg_rd && reg_addr == iqsme_pkg::OFS_STEP |=>
    reg_rdata == {16'h0000, step_q})
    else $error("step count readback wrong");
endmodule

bind iqsme_engine iqsme_engine_assertions #(
  .W_MAX(W_MAX),
  .SAMP_AW(SAMP_AW)
) u_iqsme_engine_assertions (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .dac_i(dac_i),
  .dac_q(dac_q),
  .dac_load(dac_load)
);

// ### bench/iqsme_dac_model.sv
// Two-channel DAC model that records the first 256 loaded I/Q pairs
`timescale 1ns/1ps
module iqsme_dac_model (
  // Clock
  input wire logic sys_clk,
  // Capture control
  input wire logic clr,
  // DAC inputs
  input wire logic [iqsme_pkg::DAC_W-1:0] dac_i,
  input wire logic [iqsme_pkg::DAC_W-1:0] dac_q,
  input wire logic dac_load
);
  logic [iqsme_pkg::DAC_W-1:0] cap_i [0:255];
  logic [iqsme_pkg::DAC_W-1:0] cap_q [0:255];
  int cnt = 0;

  // Both channels latch on one load; extra loads beyond 256 are dropped
  always @(posedge sys_clk) begin
    if (clr) begin
      cnt <= 0;
    end else if (dac_load && cnt < 256) begin
      cap_i[cnt] <= dac_i;
      cap_q[cnt] <= dac_q;
      cnt <= cnt + 1;
    end
  end
endmodule

// ### bench/iqsme_engine_tb.sv
// Register-driven bench for the I/Q symbol mapper engine
`timescale 1ns/1ps
module iqsme_engine_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] dac_i;
  logic [11:0] dac_q;
  logic dac_load;
  logic clr = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rv;
  logic [7:0] bits = 8'hb4;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h3c};
  logic [31:0] re [5] = '{32'h453, 32'h1e, 32'h24, 32'h0, 32'h0};

  always #4 sys_clk = ~sys_clk;

  iqsme_engine u_iqsme_engine (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dac_i(dac_i), .dac_q(dac_q),
    .dac_load(dac_load)
  );
  iqsme_dac_model u_iqsme_dac_model (
    .sys_clk(sys_clk), .clr(clr), .dac_i(dac_i), .dac_q(dac_q),
    .dac_load(dac_load)
  );

  // ----------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic chk32(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk12(input string n, input logic [11:0] e,
                       input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_loads(input int n);
    int k;
    k = 0;
    while (u_iqsme_dac_model.cnt < n && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    if (u_iqsme_dac_model.cnt < n) begin
      num_errors++;
      end_of_test();
    end
  endtask

  // Word j after serial-to-parallel and converter, MSB is first bit
  function automatic logic [3:0] word_of(input int sp, input int cv,
                                         input int wid, input int j);
    logic [3:0] w;
    int idx;
    w = 4'h0;
    for (int t = 0; t < wid; t++) begin
      idx = (sp == 3) ? (j / wid) * wid * wid + j % wid + t * wid
                      : j * wid + t;
      w = {w[2:0], bits[idx]};
    end
    return (cv == 2) ? (w ^ (w >> 1)) : w;
  endfunction

  // Two passes over the stream; cmp=0 only checks Q/I pairing
  task automatic run(input int sp, input int cv, input int wid,
                     input int nw, input int amp, input int ph,
                     input bit cmp);
    int s;
    int di;
    int dq;
    wr(iqsme_pkg::OFS_SHIFT, 32'((ph << 8) | amp));
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(iqsme_pkg::OFS_CTRL,
       32'((1 << 10) | (wid << 6) | (cv << 4) | (sp << 1) | 1));
    wait_loads(nw * 4);
    wr(iqsme_pkg::OFS_CTRL, 32'h0);
    repeat (8) @(posedge sys_clk);
    for (int n = 0; n < nw * 4; n++) begin
      s = cmp ? int'(word_of(sp, cv, wid, (n / 2) % nw)) : 0;
      di = s * 8 + n % 2 - 427;
      dq = s * 8 + n % 2 + 341;
      if (cmp) begin
        chk12("dac_q", 12'(683 + dq + ((dq * amp * 41) >>> 12)),
              u_iqsme_dac_model.cap_q[n]);
        chk12("dac_i", 12'(683 + di + ((dq * ph * 71) >>> 12)),
              u_iqsme_dac_model.cap_i[n]);
      end else begin
        chk12("q minus i", 12'h300, u_iqsme_dac_model.cap_q[n] -
              u_iqsme_dac_model.cap_i[n]);
      end
    end
    $display("Test done: mode %0d converter %0d width %0d", sp, cv, wid);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk12("dac_i", 12'h2ab, dac_i);
    chk12("dac_q", 12'h2ab, dac_q);
    for (int n = 0; n < 5; n++) begin
      rd(ra[n], rv);
      chk32("reset value", re[n], rv);
    end
    wr(iqsme_pkg::OFS_CTRL, 32'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, rv);
    chk32("unmapped", 32'h0, rv);
    wr(iqsme_pkg::OFS_STEP, 32'h3);
    rd(iqsme_pkg::OFS_STEP, rv);
    chk32("step", 32'h3, rv);
    $display("Test done: registers");
    wr(iqsme_pkg::OFS_PATLEN, 32'h2);
    for (int s = 0; s < 16; s++) begin
      wr(iqsme_pkg::OFS_PATADDR, 32'(s * 64));
      for (int k = 0; k < 2; k++) begin
        wr(iqsme_pkg::OFS_PATDATA,
           32'(((1024 + s * 8 + k) << 16) | (256 + s * 8 + k)));
      end
    end
    rd(iqsme_pkg::OFS_PATADDR, rv);
    chk32("pattern address", 32'h3c2, rv);
    wr(iqsme_pkg::OFS_BITADDR, 32'h0);
    wr(iqsme_pkg::OFS_BITDATA, {24'h0, bits});
    rd(iqsme_pkg::OFS_BITADDR, rv);
    chk32("bit address", 32'h1, rv);
    // Order 2 doubles the expanded length, so 2049 bits overflow
    wr(iqsme_pkg::OFS_CTRL, 32'h800);
    wr(iqsme_pkg::OFS_BITLEN, 32'h801);
    rd(iqsme_pkg::OFS_STATUS, rv);
    chk32("status", 32'h2, rv);
    wr(iqsme_pkg::OFS_BITLEN, 32'h8);
    rd(iqsme_pkg::OFS_STATUS, rv);
    chk32("status", 32'h0, rv);
    run(1, 1, 1, 8, 0, 0, 1'b1);
    run(2, 2, 2, 4, 0, 0, 1'b1);
    run(3, 1, 2, 4, 0, 0, 1'b1);
    run(2, 1, 4, 2, 0, 0, 1'b1);
    run(4, 1, 1, 8, 0, 0, 1'b0);
    run(1, 3, 1, 8, 0, 0, 1'b0);
    wr(iqsme_pkg::OFS_STEP, 32'h1e);
    run(2, 1, 2, 4, 10, 5, 1'b1);
    end_of_test();
  end
endmodule
